//--- logic/acsc_pkg.sv
// Constants shared by the channel status and control register slice
package acsc_pkg;
  // Register offsets
  localparam logic [7:0] OUT_STATE_OFS   = 8'h05;
  localparam logic [7:0] PLAY_MUTE_OFS   = 8'h06;
  localparam logic [7:0] FOLD_DIAG_OFS   = 8'h07;
  localparam logic [7:0] GAIN_OFS        = 8'h08;
  localparam logic [7:0] CUR_LIMIT_OFS   = 8'h09;
  localparam logic [7:0] SW_FREQ_OFS     = 8'h0A;
  // Field positions
  localparam int UPPER_LSB            = 4;
  localparam int THERMAL_DIS_BIT      = 0;
  localparam int FOLD_REPORT_BIT      = 7;
  localparam int SYNC_PULSE_BIT       = 6;
  localparam int PHASE_BIT            = 5;
  localparam int HARD_STOP_BIT        = 4;
  localparam int FAULT_CFG_LSB        = 2;
  localparam int FREQ_LSB             = 0;
  // Reset values and unmapped read value
  localparam logic [7:0] GAIN_RST      = 8'hAA;
  localparam logic [7:0] CUR_LIMIT_RST = 8'hF0;
  localparam logic [7:0] SW_FREQ_RST   = 8'h0D;
  localparam logic [3:0] HIGHZ_RST     = 4'hF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Gain codes
  localparam logic [1:0] GAIN_12DB = 2'h0;
  localparam logic [1:0] GAIN_20DB = 2'h1;
  localparam logic [1:0] GAIN_26DB = 2'h2;
  localparam logic [1:0] GAIN_32DB = 2'h3;
  // Switching frequency codes
  localparam logic [1:0] FREQ_500K   = 2'h0;
  localparam logic [1:0] FREQ_417K   = 2'h1;
  localparam logic [1:0] FREQ_357K   = 2'h2;
  localparam logic [1:0] FREQ_ILLEGAL = 2'h3;
  // Fault pin sources
  localparam logic [1:0] FAULT_TWEETER = 2'h0;
  localparam logic [1:0] FAULT_CLIP    = 2'h1;
  localparam logic [1:0] FAULT_OTW     = 2'h2;
  localparam logic [1:0] FAULT_NORMAL  = 2'h3;
endpackage

//--- logic/acsc_regs.sv
// Channel status and control register slice with link-side access port
`timescale 1ns/1ps
module acsc_regs
  import acsc_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             link_clk,
  input  wire logic             reg_req,
  input  wire logic             reg_write,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic                  reg_busy,
  output logic                  reg_done,
  output logic      [7:0]       reg_rdata,
  input  wire logic [3:0]       ch_pos_low,
  input  wire logic [3:0]       ch_neg_low,
  input  wire logic [3:0]       ch_highz,
  input  wire logic [3:0]       ch_muted,
  input  wire logic [3:0]       ch_playing,
  input  wire logic [3:0]       ch_thermal_reduce,
  input  wire logic [3:0]       ch_diag_running,
  input  wire logic [3:0]       ch_load_check_start,
  input  wire logic             clip_detect,
  input  wire logic             otw_detect,
  input  wire logic             tweeter_detect,
  output logic      [7:0]       ch_gain_field,
  output logic      [3:0]       ch_current_limit_level,
  output logic                  thermal_reduce_disable,
  output logic                  fault_pin_foldback_report,
  output logic                  sync_pulse,
  output logic                  phase_shift,
  output logic                  hard_stop,
  output logic      [1:0]       fault_pin_config,
  output logic      [1:0]       switching_freq_select,
  output logic                  fault_report_pin_out,
  output logic                  fault_report_pin_oe
);

  // Refuse channel counts the fixed bit map cannot serve
  if (CHANNELS != 4) begin : g_chan_check
    $error("acsc_regs serves exactly four channels");
  end

  localparam int NSYNC = 27;
  localparam logic [NSYNC-1:0] SYNC_RST = {23'h0, HIGHZ_RST};

  // ---------------- Link domain ----------------
  logic       req_tog;
  logic       held_write;
  logic [7:0] held_addr;
  logic [7:0] held_wdata;
  logic [2:0] ack_sync;
  logic       ack_seen;
  // Answer side flops, written only on core_clk
  logic       core_ack_tog;
  logic [7:0] core_rdata;
  wire        ack_event = ack_sync[1] ^ ack_sync[2];

  // Capture a request and launch it with a toggle
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_tog    <= 1'b0;
      held_write <= 1'b0;
      held_addr  <= 8'h00;
      held_wdata <= 8'h00;
    end else if (reg_req && !reg_busy) begin
      req_tog    <= ~req_tog;
      held_write <= reg_write;
      held_addr  <= reg_addr;
      held_wdata <= reg_wdata;
    end
  end

  // Bring the acknowledge toggle back and finish
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_sync <= 3'h0;
      ack_seen <= 1'b0;
      reg_done <= 1'b0;
    end else begin
      ack_sync <= {ack_sync[1:0], core_ack_tog};
      reg_done <= ack_event;
      if (ack_event) begin
        ack_seen <= ~ack_seen;
      end
    end
  end

  // Busy until the core answers
  assign reg_busy  = req_tog ^ ack_seen;
  assign reg_rdata = core_rdata;

  // ---------------- Core domain ----------------
  logic [2:0]       req_sync;
  logic [NSYNC-1:0] in_ff1;
  logic [NSYNC-1:0] in_ff2;
  logic [NSYNC-1:0] in_ff3;
  logic [NSYNC-1:0] in_flt;
  logic [7:0]       gain_reg;
  logic [7:0]       limit_reg;
  logic [7:0]       freq_reg;

  // Held request fields stay still while the toggle is in flight
  wire core_event = req_sync[1] ^ req_sync[2];
  wire core_wr    = core_event && held_write;

  // Three-stage filter on every pin input except ch_load_check_start, which gates load_flag unfiltered
  wire [NSYNC-1:0] raw_in = {tweeter_detect, otw_detect, clip_detect,
                             ch_diag_running, ch_thermal_reduce,
                             ch_playing, ch_muted,
                             ch_pos_low & ch_neg_low, ch_highz};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ff1 <= SYNC_RST;
      in_ff2 <= SYNC_RST;
      in_ff3 <= SYNC_RST;
      in_flt <= SYNC_RST;
    end else begin
      in_ff1 <= raw_in;
      in_ff2 <= in_ff1;
      in_ff3 <= in_ff2;
      in_flt <= (in_ff2 & ~(in_ff2 ^ in_ff3)) | (in_flt & (in_ff2 ^ in_ff3));
    end
  end

  // Live channel flags
  wire [3:0] highz_flag    = in_flt[3:0];
  wire [3:0] grounded_flag = in_flt[7:4];
  wire [3:0] muted_flag    = in_flt[11:8];
  wire [3:0] playing_flag  = in_flt[15:12];
  wire [3:0] thermal_flag  = in_flt[19:16] & {4{~thermal_reduce_disable}};
  wire [3:0] load_flag     = in_flt[23:20] & ch_load_check_start;
  wire       clip_s        = in_flt[24];
  wire       otw_s         = in_flt[25];
  wire       tweeter_s     = in_flt[26];

  // Status words
  // output state word
  wire [7:0] out_state_word = {grounded_flag, highz_flag};
  wire [7:0] play_mute_word = {muted_flag, playing_flag};
  wire [7:0] fold_diag_word = {thermal_flag, load_flag};

  // Read selection, live values
  wire [7:0] core_read_word;
  assign core_read_word =
      (held_addr == OUT_STATE_OFS) ? out_state_word :
      (held_addr == PLAY_MUTE_OFS) ? play_mute_word :
      (held_addr == FOLD_DIAG_OFS) ? fold_diag_word :
      (held_addr == GAIN_OFS)      ? gain_reg :
      (held_addr == CUR_LIMIT_OFS) ? limit_reg :
      (held_addr == SW_FREQ_OFS)   ? freq_reg : UNMAPPED_READ;

  // keep old frequency when code 11 written
  wire [1:0] next_freq_field =
      (held_wdata[FREQ_LSB+:2] == FREQ_ILLEGAL) ?
      freq_reg[FREQ_LSB+:2] : held_wdata[FREQ_LSB+:2];

  // Request handshake on the core side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync     <= 3'h0;
      core_ack_tog <= 1'b0;
      core_rdata   <= 8'h00;
    end else begin
      req_sync <= {req_sync[1:0], req_tog};
      if (core_event) begin
        core_rdata   <= core_read_word;
        core_ack_tog <= ~core_ack_tog;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg  <= GAIN_RST;
      limit_reg <= CUR_LIMIT_RST;
      freq_reg  <= SW_FREQ_RST;
    end else if (core_wr) begin
      if (held_addr == GAIN_OFS) begin
        gain_reg <= held_wdata;
      end
      if (held_addr == CUR_LIMIT_OFS) begin
        limit_reg <= held_wdata;
      end
      if (held_addr == SW_FREQ_OFS) begin
        freq_reg <= {held_wdata[7:2], next_freq_field};
      end
    end
  end

  // Control fields out
  // gain code per channel pair of bits
  assign ch_gain_field             = gain_reg;
  assign ch_current_limit_level    = limit_reg[UPPER_LSB+:4];
  assign thermal_reduce_disable    = limit_reg[THERMAL_DIS_BIT];
  assign fault_pin_foldback_report = freq_reg[FOLD_REPORT_BIT];
  assign sync_pulse                = freq_reg[SYNC_PULSE_BIT];
  assign phase_shift               = freq_reg[PHASE_BIT];
  assign hard_stop                 = freq_reg[HARD_STOP_BIT];
  assign fault_pin_config          = freq_reg[FAULT_CFG_LSB+:2];
  assign switching_freq_select     = freq_reg[FREQ_LSB+:2];

  wire fault_src =
      (fault_pin_config == FAULT_TWEETER) ? tweeter_s :
      (fault_pin_config == FAULT_CLIP)    ? clip_s :
      (fault_pin_config == FAULT_OTW)     ? otw_s : (clip_s | otw_s);
  wire fault_any = fault_src |
                   (fault_pin_foldback_report & (|thermal_flag));

  // Open-drain pin, pulled low on a fault
  logic fault_drive;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_drive <= 1'b0;
    end else begin
      fault_drive <= fault_any;
    end
  end
  assign fault_report_pin_out = 1'b0;
  assign fault_report_pin_oe  = fault_drive;

  // ---------------- Checks ----------------
  property p_grounded_both;
    @(posedge core_clk) disable iff (!rst_n)
    (ch_pos_low[0] && ch_neg_low[0]) [*5] |-> ##1 out_state_word[4];
  endproperty
  a_grounded_both: assert property (p_grounded_both)
    else $error("grounded flag missing after both terminals low");

  property p_grounded_one;
    @(posedge core_clk) disable iff (!rst_n)
    (ch_pos_low[3] && !ch_neg_low[3]) [*5] |-> ##1 !out_state_word[7];
  endproperty
  a_grounded_one: assert property (p_grounded_one)
    else $error("grounded flag set with one terminal high");

  property p_highz;
    @(posedge core_clk) disable iff (!rst_n)
    (!ch_highz[2]) [*5] |-> ##1 !out_state_word[2];
  endproperty
  a_highz: assert property (p_highz)
    else $error("high-impedance flag stuck");

  property p_muted;
    @(posedge core_clk) disable iff (!rst_n)
    ch_muted[1] [*5] |-> ##1 play_mute_word[5];
  endproperty
  a_muted: assert property (p_muted)
    else $error("mute flag not reported");

  property p_playing;
    @(posedge core_clk) disable iff (!rst_n)
    (!ch_playing[0]) [*5] |-> ##1 !play_mute_word[0];
  endproperty
  a_playing: assert property (p_playing)
    else $error("play flag held without play");

  property p_fold_dis;
    @(posedge core_clk) disable iff (!rst_n)
    limit_reg[THERMAL_DIS_BIT] |-> fold_diag_word[7:4] == 4'h0;
  endproperty
  a_fold_dis: assert property (p_fold_dis)
    else $error("foldback reported while disabled");

  property p_load;
    @(posedge core_clk) disable iff (!rst_n)
    (ch_diag_running[2] && ch_load_check_start[2]) [*5] |->
      ##1 (fold_diag_word[2] || !ch_load_check_start[2]);
  endproperty
  a_load: assert property (p_load)
    else $error("load check flag missing");

  property p_gain_wr;
    @(posedge core_clk) disable iff (!rst_n)
    (core_wr && held_addr == GAIN_OFS) |=> ch_gain_field == $past(held_wdata);
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain write lost");

  property p_limit_wr;
    @(posedge core_clk) disable iff (!rst_n)
    (core_wr && held_addr == CUR_LIMIT_OFS) |=>
      ch_current_limit_level == $past(held_wdata[7:4]);
  endproperty
  a_limit_wr: assert property (p_limit_wr)
    else $error("current limit write lost");

  property p_freq_bad;
    @(posedge core_clk) disable iff (!rst_n)
    (core_wr && held_addr == SW_FREQ_OFS && held_wdata[1:0] == FREQ_ILLEGAL)
      |=> $stable(switching_freq_select);
  endproperty
  a_freq_bad: assert property (p_freq_bad)
    else $error("illegal frequency code accepted");

  property p_status_wr;
    @(posedge core_clk) disable iff (!rst_n)
    (core_wr && held_addr == OUT_STATE_OFS) |=>
      $stable(gain_reg) && $stable(limit_reg) && $stable(freq_reg);
  endproperty
  a_status_wr: assert property (p_status_wr)
    else $error("status write changed control state");

  property p_fault_cfg;
    @(posedge core_clk) disable iff (!rst_n)
    (fault_pin_config == FAULT_CLIP && !fault_pin_foldback_report &&
     clip_s && $stable(fault_pin_config)) |=> fault_report_pin_oe;
  endproperty
  a_fault_cfg: assert property (p_fault_cfg)
    else $error("clip not driven on fault pin");

endmodule

//--- tb/acsc_host_model.sv
// Host model issuing register transfers on the link handshake
`timescale 1ns/1ps
module acsc_host_model (
  input  wire logic       link_clk,
  input  wire logic       reg_busy,
  input  wire logic       reg_done,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_req,
  output logic            reg_write,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  // Idle request lines at time zero
  initial begin
    reg_req = 1'b0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One transfer, one outstanding; idle lines invert so stale data shows
  task automatic xfer(input logic wr, input logic [7:0] a, d,
                      output logic [7:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q = 8'h00;
    @(posedge link_clk);
    reg_req <= 1'b1;
    reg_write <= wr;
    reg_addr <= a;
    reg_wdata <= d;
    do @(posedge link_clk); while (reg_busy !== 1'b0);
    reg_req <= 1'b0;
    reg_write <= ~wr;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    for (n = 0; n < 40; n++) begin
      @(posedge link_clk);
      if (reg_done === 1'b1) begin
        q = reg_rdata;
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule

//--- tb/acsc_regs_tb_top.sv
// Self-checking bench for the channel status and control registers
`timescale 1ns/1ps
module acsc_regs_tb_top;
  import acsc_pkg::*;
  typedef struct {logic wr; logic [7:0] a, d, e;} acsc_row_t;
  logic       core_clk, link_clk, rst_n;
  logic       reg_req, reg_write, reg_busy, reg_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ch_gain_field, q;
  logic [3:0] ch_pos_low, ch_neg_low, ch_highz, ch_muted, ch_playing;
  logic [3:0] ch_thermal_reduce, ch_diag_running, ch_load_check_start;
  logic [3:0] ch_current_limit_level;
  logic       clip_detect, otw_detect, tweeter_detect, pin_out, pin_oe;
  logic       thermal_reduce_disable, fold_rep;
  logic       sync_pulse, phase_shift, hard_stop;
  logic [1:0] fault_pin_config, switching_freq_select;
  int         n_mismatch, n_compared, i;
  // Ordinary cases: writes then read-backs, status read with fixed inputs
  acsc_row_t rows[20] = '{
    '{1'b1,8'h08,8'h00,8'h00}, '{1'b0,8'h08,8'h00,8'h00},  // gain codes
    '{1'b1,8'h08,8'h1B,8'h00}, '{1'b0,8'h08,8'h00,8'h1B},
    '{1'b1,8'h08,8'hFF,8'h00}, '{1'b0,8'h08,8'h00,8'hFF},
    '{1'b1,8'h09,8'h50,8'h00}, '{1'b0,8'h09,8'h00,8'h50},
    '{1'b0,8'h07,8'h00,8'h96}, '{1'b1,8'h09,8'hA1,8'h00},
    '{1'b0,8'h09,8'h00,8'hA1}, '{1'b0,8'h07,8'h00,8'h06},
    '{1'b1,8'h0A,8'hF6,8'h00}, '{1'b0,8'h0A,8'h00,8'hF6},  // freq 357k
    '{1'b1,8'h0A,8'h0F,8'h00}, '{1'b0,8'h0A,8'h00,8'h0E},  // 11 dropped
    '{1'b1,8'h05,8'hFF,8'h00}, '{1'b0,8'h05,8'h00,8'h1A},
    '{1'b0,8'h06,8'h00,8'hC3}, '{1'b0,8'h20,8'h00,8'h00}};
  logic [7:0] rst_a[3] = '{8'h08, 8'h09, 8'h0A};
  logic [7:0] rst_e[3] = '{8'hAA, 8'hF0, 8'h0D};

  // Clocks, unrelated in phase
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  initial link_clk = 1'b0;
  always #7.5 link_clk = ~link_clk;

  acsc_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
    .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_busy(reg_busy), .reg_done(reg_done),
    .reg_rdata(reg_rdata), .ch_pos_low(ch_pos_low),
    .ch_neg_low(ch_neg_low), .ch_highz(ch_highz), .ch_muted(ch_muted),
    .ch_playing(ch_playing), .ch_thermal_reduce(ch_thermal_reduce),
    .ch_diag_running(ch_diag_running),
    .ch_load_check_start(ch_load_check_start),
    .clip_detect(clip_detect), .otw_detect(otw_detect),
    .tweeter_detect(tweeter_detect), .ch_gain_field(ch_gain_field),
    .ch_current_limit_level(ch_current_limit_level),
    .thermal_reduce_disable(thermal_reduce_disable),
    .fault_pin_foldback_report(fold_rep), .sync_pulse(sync_pulse),
    .phase_shift(phase_shift), .hard_stop(hard_stop),
    .fault_pin_config(fault_pin_config),
    .switching_freq_select(switching_freq_select),
    .fault_report_pin_out(pin_out), .fault_report_pin_oe(pin_oe));

  acsc_host_model HOST (.link_clk(link_clk), .reg_busy(reg_busy),
    .reg_done(reg_done), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // Compare and count
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Transfer through the host model; no answer counts as a mismatch
  task automatic acc(input logic wr, input logic [7:0] a, d);
    bit ok;
    HOST.xfer(wr, a, d, q, ok);
    if (!ok) begin
      n_mismatch++;
      $display("[FAIL] %0t no answer at %h", $time, a);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #50us;
    n_mismatch++;
    conclude();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_n = 1'b0;
    ch_pos_low = 4'h3;
    ch_neg_low = 4'h5;
    ch_highz = 4'hA;
    ch_muted = 4'hC;
    ch_playing = 4'h3;
    ch_thermal_reduce = 4'h9;
    ch_diag_running = 4'hF;
    ch_load_check_start = 4'h6;
    clip_detect = 1'b0;
    otw_detect = 1'b0;
    tweeter_detect = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 20; i++) begin
      acc(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(q, rows[i].e);
    end
    // Control fields reach the outputs
    chk(ch_gain_field, 8'hFF);
    chk({4'h0, ch_current_limit_level}, 8'h0A);
    chk({7'h0, thermal_reduce_disable}, 8'h01);
    chk({6'h0, switching_freq_select}, 8'h02);
    acc(1'b1, 8'h0A, 8'hF1);
    chk({6'h0, switching_freq_select}, 8'h01);
    chk({6'h0, fault_pin_config}, 8'h00);
    chk({4'h0, fold_rep, sync_pulse, phase_shift, hard_stop}, 8'h0F);
    // Fault pin reports tweeter only with configuration 00
    @(posedge core_clk);
    tweeter_detect <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({6'h0, pin_oe, pin_out}, 8'h02);
    tweeter_detect <= 1'b0;
    clip_detect <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({7'h0, pin_oe}, 8'h00);
    // Clip, warning and normal sources in turn
    acc(1'b1, 8'h0A, 8'h05);
    chk({7'h0, pin_oe}, 8'h01);
    acc(1'b1, 8'h0A, 8'h09);
    chk({7'h0, pin_oe}, 8'h00);
    otw_detect <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({7'h0, pin_oe}, 8'h01);
    acc(1'b1, 8'h0A, 8'h0D);
    chk({7'h0, pin_oe}, 8'h01);
    clip_detect <= 1'b0;
    otw_detect <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk({7'h0, pin_oe}, 8'h00);
    // Status follows live inputs
    ch_highz <= 4'h5;
    ch_neg_low <= 4'h3;
    repeat (8) @(posedge core_clk);
    acc(1'b0, 8'h05, 8'h00);
    chk(q, 8'h35);
    // Second reset mid-run restores control defaults
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(ch_gain_field, 8'hAA);
    chk({6'h0, reg_busy, reg_done}, 8'h00);
    rst_n <= 1'b1;
    for (i = 0; i < 3; i++) begin
      acc(1'b0, rst_a[i], 8'h00);
      chk(q, rst_e[i]);
    end
    conclude();
  end
endmodule
